/* hdl/pobp_pkg.sv */
// constants, types and register map of the protected output breaker block
//==============================================================
// Overview of operation
// - every output line owns its own breaker
// - current below lower limit opens line
// - current above upper limit opens line
// - limits checked once per programmable sample tick
// - trip after N consecutive bad samples, default 1
// - per-line auto-retry enable mask
// - auto-retry recloses after programmable sample interval
// - live trip mask, one bit per breaker
// - sticky trip mask, cleared by reading it
// - reset mask bit 1 recloses, 0 ignores
// - port config applies to all masked lines
// - pulse settings held separately per line
// - pulse modes off/rise/fall/both/continuous/while-high
// - pulse train duration programmable in microseconds
// - pulse train period programmable in microseconds
// - duty fraction programmable from 0 to 1
package pobp_pkg;
	localparam int LINES = 8;
	localparam int CUR_W = 16;
	localparam int CLK_HZ = 40000000;
	localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	localparam int US_NS = 1000;
	localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
	localparam logic [11:0] OFS_OUT = 12'h000;
	localparam logic [11:0] OFS_UNDER = 12'h004;
	localparam logic [11:0] OFS_OVER = 12'h008;
	localparam logic [11:0] OFS_SAMPLE_US = 12'h00c;
	localparam logic [11:0] OFS_TRIP_COUNT = 12'h010;
	localparam logic [11:0] OFS_RETRY_SAMPLES = 12'h014;
	localparam logic [11:0] OFS_RETRY_EN = 12'h018;
	localparam logic [11:0] OFS_LIVE_TRIP = 12'h01c;
	localparam logic [11:0] OFS_STICKY_TRIP = 12'h020;
	localparam logic [11:0] OFS_RESET_MASK = 12'h024;
	localparam logic [11:0] OFS_CFG_MASK = 12'h028;
	localparam logic [11:0] OFS_LINE_SEL = 12'h02c;
	localparam logic [11:0] OFS_PS_MODE = 12'h030;
	localparam logic [11:0] OFS_PS_DUR = 12'h034;
	localparam logic [11:0] OFS_PS_PERIOD = 12'h038;
	localparam logic [11:0] OFS_PS_HIGH = 12'h03c;
	localparam logic [15:0] UNDER_RST = 16'h0000;
	localparam logic [15:0] OVER_RST = 16'hffff;
	localparam logic [15:0] SAMPLE_US_RST = 16'h0064;
	localparam logic [7:0] TRIP_COUNT_RST = 8'h01;
	localparam logic [15:0] RETRY_RST = 16'h000a;
	localparam logic [7:0] CFG_MASK_RST = 8'hff;
	localparam logic [7:0] HIGH_FULL = 8'hff;
	typedef enum logic [2:0] {
		PSM_OFF, PSM_RISE, PSM_FALL, PSM_BOTH, PSM_CONT, PSM_WHILE_HIGH
	} pobp_psmode_type;
	typedef enum logic {BRK_CLOSED, BRK_TRIPPED} pobp_brkstate_type;
endpackage

/* hdl/pobp_breaker.sv */
// one line's current breaker with its own limits, counters and retry timer
`timescale 1ns/1ps
module pobp_breaker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sampleTick,
	input wire logic [15:0] lineCurrent,
	input wire logic [15:0] cfgData,
	input wire logic wrUnder,
	input wire logic wrOver,
	input wire logic wrCount,
	input wire logic wrRetry,
	input wire logic retryEnable,
	input wire logic manualReset,
	output logic tripped,
	output logic tripEvent
);
	logic [15:0] underFf;
	logic [15:0] overFf;
	logic [7:0] countFf;
	logic [15:0] retryFf;
	logic [7:0] badCntFf;
	logic [15:0] retryCntFf;
	pobp_pkg::pobp_brkstate_type stateFf;
	logic outOfLimit;
	logic [7:0] nxt_badCnt;
	logic [7:0] tripAt;
	logic retryDue;

	//==============================================================
	// per-line limits
	// masked port config
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			underFf <= pobp_pkg::UNDER_RST;
			overFf <= pobp_pkg::OVER_RST;
			countFf <= pobp_pkg::TRIP_COUNT_RST;
			retryFf <= pobp_pkg::RETRY_RST;
		end else begin
			if (wrUnder) underFf <= cfgData;
			if (wrOver) overFf <= cfgData;
			if (wrCount) countFf <= cfgData[7:0];
			if (wrRetry) retryFf <= cfgData;
		end
	end

	//==============================================================
	// limit check and trip
	// both limits
	assign outOfLimit = (lineCurrent < underFf) || (lineCurrent > overFf);
	assign nxt_badCnt = badCntFf + 8'h01;
	assign tripAt = (countFf == 8'h00) ? 8'h01 : countFf;
	assign retryDue = retryEnable && ((retryCntFf + 16'h0001) >= retryFf);
	assign tripped = (stateFf == pobp_pkg::BRK_TRIPPED);
	assign tripEvent = sampleTick && !tripped && outOfLimit && (nxt_badCnt >= tripAt);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateFf <= pobp_pkg::BRK_CLOSED;
			badCntFf <= 8'h00;
			retryCntFf <= 16'h0000;
		end else begin
			case (stateFf)
				pobp_pkg::BRK_CLOSED: begin
					if (tripEvent) begin
						stateFf <= pobp_pkg::BRK_TRIPPED;
						badCntFf <= 8'h00;
						retryCntFf <= 16'h0000;
					end else if (sampleTick) begin
						badCntFf <= outOfLimit ? nxt_badCnt : 8'h00;
					end
				end
				pobp_pkg::BRK_TRIPPED: begin
					if (manualReset) begin
						stateFf <= pobp_pkg::BRK_CLOSED;
						retryCntFf <= 16'h0000;
					end else if (sampleTick) begin
						if (retryDue) begin
							stateFf <= pobp_pkg::BRK_CLOSED;
							retryCntFf <= 16'h0000;
						end else begin
							retryCntFf <= retryCntFf + 16'h0001;
						end
					end
				end
				default: stateFf <= pobp_pkg::BRK_CLOSED;
			endcase
		end
	end

	//==============================================================
	// checks
	inLimitNoTrip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sampleTick && !tripped && !outOfLimit) |=> (!tripped && badCntFf == 8'h00))
		else $error("breaker moved on an in-limit sample");
	tripAfterCount_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(tripped) |-> ($past(sampleTick) && $past(nxt_badCnt) >= $past(tripAt)))
		else $error("breaker tripped before the consecutive count");
	manualReclose_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tripped && manualReset) |=> !tripped)
		else $error("manual reset did not reclose");
	noRetryOff_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tripped && !retryEnable && !manualReset) |=> tripped)
		else $error("breaker reclosed without retry or reset");
	cover property (@(posedge ref_clk) disable iff (!rst_n) tripped && retryDue && sampleTick);
endmodule

/* hdl/pobp_top.sv */
// apb slave, sample timing, breakers and per-line pulse shaping of the output port
`timescale 1ns/1ps
module pobp_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [127:0] lineCurrents,
	output logic [7:0] lineDrive
);
	localparam int N = pobp_pkg::LINES;
	logic setup;
	logic access;
	logic wrAcc;
	logic rdAcc;
	logic mapped;
	logic [31:0] readMux;
	logic [31:0] prdataFf;
	logic errFf;
	logic [7:0] outStateFf;
	logic [15:0] underFf;
	logic [15:0] overFf;
	logic [15:0] sampleUsFf;
	logic [7:0] tripCountFf;
	logic [15:0] retryFf;
	logic [7:0] retryEnFf;
	logic [7:0] cfgMaskFf;
	logic [2:0] lineSelFf;
	logic [7:0] stickyFf;
	logic [7:0] liveTrip;
	logic [7:0] tripEvents;
	logic [7:0] resetReq;
	logic [7:0] lineDriveFf;
	logic [7:0] pulseOut;
	logic [5:0] usCntFf;
	logic usTick;
	logic [15:0] sampleCntFf;
	logic sampleTick;
	logic [2:0] modeFf [N];
	logic [15:0] durFf [N];
	logic [15:0] periodFf [N];
	logic [7:0] highFf [N];

	//==============================================================
	// apb decode: setup latches read data, access always ready
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wrAcc = access && pwrite && !errFf;
	assign rdAcc = access && !pwrite && !errFf;
	assign pready = access;
	assign prdata = prdataFf;
	assign pslverr = access && errFf;

	always_comb begin
		mapped = 1'b1;
		readMux = 32'h00000000;
		case (paddr)
			pobp_pkg::OFS_OUT: readMux = {24'h000000, outStateFf};
			pobp_pkg::OFS_UNDER: readMux = {16'h0000, underFf};
			pobp_pkg::OFS_OVER: readMux = {16'h0000, overFf};
			pobp_pkg::OFS_SAMPLE_US: readMux = {16'h0000, sampleUsFf};
			pobp_pkg::OFS_TRIP_COUNT: readMux = {24'h000000, tripCountFf};
			pobp_pkg::OFS_RETRY_SAMPLES: readMux = {16'h0000, retryFf};
			pobp_pkg::OFS_RETRY_EN: readMux = {24'h000000, retryEnFf};
			pobp_pkg::OFS_LIVE_TRIP: readMux = {24'h000000, liveTrip};
			pobp_pkg::OFS_STICKY_TRIP: readMux = {24'h000000, stickyFf};
			pobp_pkg::OFS_RESET_MASK: readMux = 32'h00000000;
			pobp_pkg::OFS_CFG_MASK: readMux = {24'h000000, cfgMaskFf};
			pobp_pkg::OFS_LINE_SEL: readMux = {29'h00000000, lineSelFf};
			pobp_pkg::OFS_PS_MODE: readMux = {29'h00000000, modeFf[lineSelFf]};
			pobp_pkg::OFS_PS_DUR: readMux = {16'h0000, durFf[lineSelFf]};
			pobp_pkg::OFS_PS_PERIOD: readMux = {16'h0000, periodFf[lineSelFf]};
			pobp_pkg::OFS_PS_HIGH: readMux = {24'h000000, highFf[lineSelFf]};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdataFf <= 32'h00000000;
			errFf <= 1'b0;
		end else if (setup) begin
			prdataFf <= pwrite ? 32'h00000000 : readMux;
			errFf <= !mapped;
		end
	end

	//==============================================================
	// port-wide registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			outStateFf <= 8'h00;
			underFf <= pobp_pkg::UNDER_RST;
			overFf <= pobp_pkg::OVER_RST;
			sampleUsFf <= pobp_pkg::SAMPLE_US_RST;
			tripCountFf <= pobp_pkg::TRIP_COUNT_RST;
			retryFf <= pobp_pkg::RETRY_RST;
			retryEnFf <= 8'h00;
			cfgMaskFf <= pobp_pkg::CFG_MASK_RST;
			lineSelFf <= 3'h0;
		end else if (wrAcc) begin
			case (paddr)
				pobp_pkg::OFS_OUT: outStateFf <= pwdata[7:0];
				pobp_pkg::OFS_UNDER: underFf <= pwdata[15:0];
				pobp_pkg::OFS_OVER: overFf <= pwdata[15:0];
				pobp_pkg::OFS_SAMPLE_US: sampleUsFf <= pwdata[15:0];
				pobp_pkg::OFS_TRIP_COUNT: tripCountFf <= pwdata[7:0];
				pobp_pkg::OFS_RETRY_SAMPLES: retryFf <= pwdata[15:0];
				pobp_pkg::OFS_RETRY_EN: retryEnFf <= pwdata[7:0];
				pobp_pkg::OFS_CFG_MASK: cfgMaskFf <= pwdata[7:0];
				pobp_pkg::OFS_LINE_SEL: lineSelFf <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	assign resetReq = (wrAcc && paddr == pobp_pkg::OFS_RESET_MASK) ? pwdata[7:0] : 8'h00;

	//==============================================================
	// sticky trip mask: clears only bits already returned, new trips win
	// read clears
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stickyFf <= 8'h00;
		end else if (rdAcc && paddr == pobp_pkg::OFS_STICKY_TRIP) begin
			stickyFf <= (stickyFf & ~prdataFf[7:0]) | tripEvents;
		end else begin
			stickyFf <= stickyFf | tripEvents;
		end
	end

	//==============================================================
	// microsecond tick and sample tick
	assign usTick = (usCntFf == 6'(pobp_pkg::CYCLES_PER_US - 1));
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			usCntFf <= 6'h00;
		end else begin
			usCntFf <= usTick ? 6'h00 : usCntFf + 6'h01;
		end
	end

	assign sampleTick = usTick && ((sampleCntFf + 16'h0001) >= sampleUsFf);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleCntFf <= 16'h0000;
		end else if (sampleTick) begin
			sampleCntFf <= 16'h0000;
		end else if (usTick) begin
			sampleCntFf <= sampleCntFf + 16'h0001;
		end
	end

	//==============================================================
	// per-line breaker and pulse shaping
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : gLine
			logic [15:0] burstFf;
			logic [15:0] phaseFf;
			logic cmdPrevFf;
			logic cmd;
			logic rise;
			logic fall;
			logic startBurst;
			logic pulse;
			logic wrSel;
			logic [31:0] phaseScaled;
			logic [31:0] highScaled;

			pobp_breaker uBrk (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.sampleTick(sampleTick),
				.lineCurrent(lineCurrents[gi*16 +: 16]),
				.cfgData(pwdata[15:0]),
				.wrUnder(wrAcc && cfgMaskFf[gi] && paddr == pobp_pkg::OFS_UNDER),
				.wrOver(wrAcc && cfgMaskFf[gi] && paddr == pobp_pkg::OFS_OVER),
				.wrCount(wrAcc && cfgMaskFf[gi] && paddr == pobp_pkg::OFS_TRIP_COUNT),
				.wrRetry(wrAcc && cfgMaskFf[gi] && paddr == pobp_pkg::OFS_RETRY_SAMPLES),
				.retryEnable(retryEnFf[gi]),
				.manualReset(resetReq[gi]),
				.tripped(liveTrip[gi]),
				.tripEvent(tripEvents[gi])
			);

			assign wrSel = wrAcc && (lineSelFf == 3'(gi));
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					modeFf[gi] <= 3'h0;
					durFf[gi] <= 16'h0000;
					periodFf[gi] <= 16'h0000;
					highFf[gi] <= 8'h00;
				end else if (wrSel) begin
					if (paddr == pobp_pkg::OFS_PS_MODE) modeFf[gi] <= pwdata[2:0];
					if (paddr == pobp_pkg::OFS_PS_DUR) durFf[gi] <= pwdata[15:0];
					if (paddr == pobp_pkg::OFS_PS_PERIOD) periodFf[gi] <= pwdata[15:0];
					if (paddr == pobp_pkg::OFS_PS_HIGH) highFf[gi] <= pwdata[7:0];
				end
			end

			assign cmd = outStateFf[gi];
			assign rise = cmd && !cmdPrevFf;
			assign fall = !cmd && cmdPrevFf;
			always_comb begin
				case (pobp_pkg::pobp_psmode_type'(modeFf[gi]))
					pobp_pkg::PSM_RISE: startBurst = rise;
					pobp_pkg::PSM_FALL: startBurst = fall;
					pobp_pkg::PSM_BOTH: startBurst = rise || fall;
					default: startBurst = 1'b0;
				endcase
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					cmdPrevFf <= 1'b0;
					burstFf <= 16'h0000;
					phaseFf <= 16'h0000;
				end else begin
					cmdPrevFf <= cmd;
					if (startBurst) begin
						burstFf <= durFf[gi];
						phaseFf <= 16'h0000;
					end else if (usTick) begin
						if (burstFf != 16'h0000) burstFf <= burstFf - 16'h0001;
						phaseFf <= ((phaseFf + 16'h0001) >= periodFf[gi]) ? 16'h0000
							: phaseFf + 16'h0001;
					end
				end
			end

			// high fraction, full scale is one
			assign phaseScaled = {16'h0000, phaseFf} * 32'(pobp_pkg::HIGH_FULL);
			assign highScaled = {16'h0000, periodFf[gi]} * {24'h000000, highFf[gi]};
			assign pulse = phaseScaled < highScaled;

			always_comb begin
				case (pobp_pkg::pobp_psmode_type'(modeFf[gi]))
					pobp_pkg::PSM_RISE, pobp_pkg::PSM_FALL, pobp_pkg::PSM_BOTH:
						pulseOut[gi] = (burstFf != 16'h0000) ? pulse : cmd;
					pobp_pkg::PSM_CONT: pulseOut[gi] = pulse;
					pobp_pkg::PSM_WHILE_HIGH: pulseOut[gi] = cmd && pulse;
					default: pulseOut[gi] = cmd;
				endcase
			end
		end
	endgenerate

	//==============================================================
	// output drive, opened while tripped
	// open and resume
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineDriveFf <= 8'h00;
		end else begin
			lineDriveFf <= pulseOut & ~liveTrip;
		end
	end
	assign lineDrive = lineDriveFf;

	//==============================================================
	// checks
	openWhileTrip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lineDriveFf & $past(liveTrip)) == 8'h00)
		else $error("tripped line still driven");
	stickySet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(tripEvents != 8'h00) |=> ((stickyFf & $past(tripEvents)) == $past(tripEvents)))
		else $error("trip event lost from sticky mask");
	usTickGap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		usTick |=> !usTick [*8])
		else $error("microsecond tick too frequent");
	sampleOnUs_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sampleTick |-> usTick)
		else $error("sample tick off the microsecond grid");
	modeOffFollow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(modeFf[0] == 3'h0 && !liveTrip[0]) |=> (lineDriveFf[0] == $past(outStateFf[0])))
		else $error("mode off line does not follow command");
	unmappedErr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(setup && !mapped) |=> (access |-> pslverr))
		else $error("unmapped access without error");
	cover property (@(posedge ref_clk) disable iff (!rst_n) tripEvents != 8'h00);
	cover property (@(posedge ref_clk) disable iff (!rst_n) (resetReq & liveTrip) != 8'h00);
	cover property (@(posedge ref_clk) disable iff (!rst_n)
		rdAcc && paddr == pobp_pkg::OFS_STICKY_TRIP && prdataFf != 32'h00000000);
endmodule

/* tb/pobp_load_model.sv */
// switched load on every output line, drawing a set current while driven
`timescale 1ns/1ps
module pobp_load_model (
	lineDrive,
	loadLevel,
	lineCurrents
);
	input wire logic [7:0] lineDrive;
	input wire logic [127:0] loadLevel;
	output logic [127:0] lineCurrents;
	//==============================================================
	// load current
	// one load per line, no current when switched off
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lineCurrents[16*i +: 16] = lineDrive[i] ? loadLevel[16*i +: 16] : 16'h0000;
		end
	end
endmodule

/* tb/protected_output_breaker_pwm_test.sv */
// self-checking bench of the protected output port with its load model
`timescale 1ns/1ps
module protected_output_breaker_pwm_test;
	localparam logic [11:0] RA[7] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h028, 12'h040};
	localparam logic [31:0] RE[7] = '{32'h00000000, 32'h0000ffff, 32'h00000064, 32'h00000001,
		32'h0000000a, 32'h000000ff, 32'h00000000};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [127:0] lineCurrents;
	logic [127:0] loadLevel = {8{16'h0100}};
	logic [7:0] lineDrive;
	logic [31:0] rd;
	logic err;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int k;
	int t0;
	pobp_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lineCurrents(lineCurrents), .lineDrive(lineDrive));
	pobp_load_model load (.lineDrive(lineDrive), .loadLevel(loadLevel),
		.lineCurrents(lineCurrents));
	initial begin
		forever begin
			#12.5 ref_clk = ~ref_clk;
		end
	end
	//==============================================================
	// shared tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			complete_run;
		end
	end
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one transfer: setup, access held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1);
		chk("access cycles", n, 32'h00000001);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, 12'h01c, 32'h00000000);
			n++;
		end while (rd[b] !== v && n < 100);
		chk("live trip bit", {31'h0, rd[b]}, {31'h0, v});
	endtask
	task automatic count_high(input int len);
		k = 0;
		repeat (len) begin
			@(posedge ref_clk);
			k += int'(lineDrive[0]);
		end
	endtask
	//==============================================================
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, RA[i], 32'h00000000);
			chk("register value", rd, RE[i]);
			chk("slave error", {31'h0, err}, {31'h0, RA[i] == 12'h040});
		end
		$display("test registers done");
		apb(1'b1, 12'h000, 32'h000000ff);
		apb(1'b1, 12'h038, 32'h00000004);
		apb(1'b1, 12'h03c, 32'h00000040);
		// half duty, only modes 4 and 5 pulse a steady line
		for (int m = 0; m < 6; m++) begin
			apb(1'b1, 12'h030, 32'(m));
			repeat (10) @(posedge ref_clk);
			count_high(320);
			chk("pulsed highs", 32'(k), (m >= 4) ? 32'h000000a0 : 32'h00000140);
		end
		// soft start burst of 8 us after a rising command
		apb(1'b1, 12'h034, 32'h00000008);
		apb(1'b1, 12'h030, 32'h00000001);
		apb(1'b1, 12'h000, 32'h000000fe);
		apb(1'b1, 12'h000, 32'h000000ff);
		count_high(400);
		chk("burst highs", {31'h0, k >= 230 && k <= 240}, 32'h00000001);
		// soft stop burst after a falling command
		apb(1'b1, 12'h030, 32'h00000002);
		apb(1'b1, 12'h000, 32'h000000fe);
		count_high(400);
		chk("stop burst highs", {31'h0, k >= 122 && k <= 161}, 32'h00000001);
		apb(1'b1, 12'h000, 32'h000000ff);
		apb(1'b1, 12'h030, 32'h00000000);
		$display("test pulse shaping done");
		apb(1'b1, 12'h004, 32'h00000010);
		apb(1'b1, 12'h008, 32'h00001000);
		apb(1'b1, 12'h00c, 32'h00000001);
		apb(1'b1, 12'h010, 32'h00000002);
		repeat (100) @(posedge ref_clk);
		apb(1'b0, 12'h01c, 32'h00000000);
		chk("no trip", rd, 32'h00000000);
		// overload on line 1 trips after two samples
		loadLevel[31:16] <= 16'h2000;
		t0 = cycles;
		poll(1, 1'b1);
		chk("trip delay", {31'h0, (cycles - t0) >= 40 && (cycles - t0) <= 95}, 32'h1);
		chk("drive after trip", {24'h0, lineDrive}, 32'h000000fd);
		apb(1'b0, 12'h020, 32'h00000000);
		chk("sticky", rd, 32'h00000002);
		apb(1'b0, 12'h020, 32'h00000000);
		chk("sticky cleared", rd, 32'h00000000);
		// manual reset of a line without retry, closed line ignored
		loadLevel[31:16] <= 16'h0100;
		apb(1'b1, 12'h024, 32'h00000003);
		apb(1'b0, 12'h01c, 32'h00000000);
		chk("manual reclose", rd, 32'h00000000);
		repeat (5) @(posedge ref_clk);
		chk("drive restored", {24'h0, lineDrive}, 32'h000000ff);
		$display("test manual reset done");
		// underload on line 2, retry every 3 samples
		apb(1'b1, 12'h018, 32'h00000004);
		apb(1'b1, 12'h014, 32'h00000003);
		loadLevel[47:32] <= 16'h0004;
		poll(2, 1'b1);
		loadLevel[47:32] <= 16'h0100;
		t0 = cycles;
		poll(2, 1'b0);
		chk("retry delay", {31'h0, (cycles - t0) <= 170}, 32'h1);
		repeat (100) @(posedge ref_clk);
		apb(1'b0, 12'h01c, 32'h00000000);
		chk("stays closed", rd, 32'h00000000);
		$display("test auto retry done");
		// reset in mid run opens every line and clears state
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("drive in reset", {24'h0, lineDrive}, 32'h00000000);
		rst_n <= 1'b1;
		apb(1'b0, 12'h018, 32'h00000000);
		chk("retry enable after reset", rd, 32'h00000000);
		apb(1'b0, 12'h000, 32'h00000000);
		chk("port after reset", rd, 32'h00000000);
		$display("test reset done");
		complete_run;
	end
endmodule
